// ---- rtl/osc_div_defs.svh ----
// register offsets, field positions, reset values and timing counts of the divider
`ifndef OSC_DIV_DEFS_SVH
`define OSC_DIV_DEFS_SVH

`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004

`define CTRL_RATE_LSB 0
`define CTRL_RATE_MSB 1
`define CTRL_SRC_BIT 2
`define CTRL_FAST_LSB 4
`define CTRL_FAST_MSB 5
`define CTRL_SLOW_LSB 8
`define CTRL_SLOW_MSB 10
`define CTRL_RESET 32'h0000_0000

`define PCLK_FREQ_KHZ 50000
`define OSC_FREQ_KHZ 12000
`define CFG_1MHZ_KHZ 1000
`define CFG_6MHZ_KHZ 6000
`define CFG_12MHZ_KHZ 12000
// half periods of the 12 MHz oscillator, as a fractional step per pclk
`define OSC_STEP (2 * `OSC_FREQ_KHZ / 1000)
`define OSC_MOD (`PCLK_FREQ_KHZ / 1000)
// oscillator half periods per config clock half period
`define CFG_HALF_1MHZ (`OSC_FREQ_KHZ / `CFG_1MHZ_KHZ)
`define CFG_HALF_6MHZ (`OSC_FREQ_KHZ / `CFG_6MHZ_KHZ)
`define CFG_HALF_12MHZ (`OSC_FREQ_KHZ / `CFG_12MHZ_KHZ)
`define POR_OSC_CYCLES 255

`endif

// ---- rtl/osc_div_pkg.sv ----
// types shared by the oscillator and divider
package osc_div_pkg;
   typedef enum logic [1:0] {
      RATE_1MHZ = 2'h0,
      RATE_6MHZ = 2'h1,
      RATE_12MHZ = 2'h2
   } cfg_rate_type;
   typedef enum logic {
      SRC_OSC = 1'h0,
      SRC_USER = 1'h1
   } div_src_type;
endpackage : osc_div_pkg

// ---- rtl/oscillator_clock_divider.sv ----
// internal oscillator, config clock output and two-output divider behind APB
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "osc_div_defs.svh"

// Notes on behaviour
// - free-running 12 MHz oscillator times power-on, config clock
// - config clock 1, 6 or 12 MHz, 1 default
// - divider source: oscillator or user clock, configured
// - fast output divides by 4, 16, 64, 256
// - slow output divides by 2 up to 65536
// - each output ratio set independently
// - oscillator variant and user clock variant
module oscillator_clock_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic user_clock,
   output logic config_clock_out,
   output logic fast_divided_output,
   output logic slow_divided_output,
   output logic por_done
);

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, so every answer comes from a flop

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [31:0] status_w;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   wire logic access_w = psel & penable;
   wire logic sel_ctrl_w = (paddr == `CTRL_OFFSET);
   wire logic sel_status_w = (paddr == `STATUS_OFFSET);
   wire logic mapped_w = sel_ctrl_w | sel_status_w;
   wire logic done_w = access_w & pready_q;
   wire logic wr_ctrl_w = done_w & pwrite & sel_ctrl_w;
   wire logic [31:0] rd_mux_w = sel_ctrl_w ? ctrl_q : (sel_status_w ? status_w : 32'h0000_0000);

   // only the documented fields are kept; other bits read zero
   assign ctrl_d = wr_ctrl_w ?
      (pwdata & 32'h0000_0737) : ctrl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         pready_q <= access_w & ~pready_q;
         prdata_q <= (access_w & ~pready_q & ~pwrite) ? rd_mux_w : 32'h0000_0000;
         pslverr_q <= access_w & ~pready_q & ~mapped_w;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   osc_div_pkg::cfg_rate_type rate_w;
   osc_div_pkg::div_src_type src_w;
   wire logic [1:0] fast_idx_w = ctrl_q[`CTRL_FAST_MSB:`CTRL_FAST_LSB];
   wire logic [2:0] slow_idx_w = ctrl_q[`CTRL_SLOW_MSB:`CTRL_SLOW_LSB];
   assign rate_w = osc_div_pkg::cfg_rate_type'(ctrl_q[`CTRL_RATE_MSB:`CTRL_RATE_LSB]);
   assign src_w = osc_div_pkg::div_src_type'(ctrl_q[`CTRL_SRC_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // oscillator: fractional accumulator makes one tick per 12 MHz half period

   localparam logic [5:0] OSC_STEP = 6'(`OSC_STEP);
   localparam logic [5:0] OSC_MOD = 6'(`OSC_MOD);
   logic [5:0] acc_q;
   logic osc_level_q;
   wire logic [6:0] acc_sum_w = {1'b0, acc_q} + {1'b0, OSC_STEP};
   wire logic half_tick_w = (acc_sum_w >= {1'b0, OSC_MOD});
   wire logic [6:0] acc_wrap_w = acc_sum_w - {1'b0, OSC_MOD};
   wire logic osc_rise_w = half_tick_w & ~osc_level_q;

   // never stops: nothing but reset holds the oscillator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 6'h00;
         osc_level_q <= 1'b0;
      end else begin
         acc_q <= half_tick_w ? acc_wrap_w[5:0] : acc_sum_w[5:0];
         osc_level_q <= osc_level_q ^ half_tick_w;
      end
   end

   // power-on time-out counted in oscillator cycles
   localparam logic [7:0] POR_LAST = 8'(`POR_OSC_CYCLES);
   logic [7:0] por_cnt_q;
   logic por_done_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_q <= 8'h00;
         por_done_q <= 1'b0;
      end else if (osc_rise_w && !por_done_q) begin
         por_cnt_q <= por_cnt_q + 8'h01;
         por_done_q <= (por_cnt_q == POR_LAST - 8'h01);
      end
   end
   assign por_done = por_done_q;

   ////////////////////////////////////////////////////////////////////////////
   // config clock output from oscillator half periods

   logic [3:0] cfg_cnt_q;
   logic cfg_out_q;
   logic [3:0] cfg_half_w;
   // unused encoding falls back to the 1 MHz default
   always_comb begin
      case (rate_w)
         osc_div_pkg::RATE_6MHZ: cfg_half_w = 4'(`CFG_HALF_6MHZ);
         osc_div_pkg::RATE_12MHZ: cfg_half_w = 4'(`CFG_HALF_12MHZ);
         default: cfg_half_w = 4'(`CFG_HALF_1MHZ);
      endcase
   end
   // >= so a rate change mid-count cannot stall the output
   wire logic cfg_flip_w = half_tick_w & (cfg_cnt_q >= cfg_half_w - 4'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_cnt_q <= 4'h0;
         cfg_out_q <= 1'b0;
      end else if (half_tick_w) begin
         cfg_cnt_q <= cfg_flip_w ? 4'h0 : cfg_cnt_q + 4'h1;
         cfg_out_q <= cfg_out_q ^ cfg_flip_w;
      end
   end
   assign config_clock_out = cfg_out_q;

   ////////////////////////////////////////////////////////////////////////////
   // divider source: oscillator or synchronised user clock

   logic [2:0] user_sync_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_sync_q <= 3'h0;
      end else begin
         user_sync_q <= {user_sync_q[1:0], user_clock};
      end
   end
   // user clock must stay below pclk/4 to be seen reliably
   wire logic user_rise_w = user_sync_q[1] & ~user_sync_q[2];
   wire logic src_edge_w = (src_w == osc_div_pkg::SRC_USER) ? user_rise_w : osc_rise_w;

   ////////////////////////////////////////////////////////////////////////////
   // binary divide counter; bit k has period 2^(k+1) source cycles

   logic [15:0] cnt_q;
   wire logic [15:0] cnt_d = src_edge_w ? cnt_q + 16'h0001 : cnt_q;
   wire logic [3:0] fast_bit_w = {1'b0, fast_idx_w, 1'b1};
   // 2,8,32,128 then 1024,4096,16384,65536
   wire logic [3:0] slow_bit_w = slow_idx_w[2] ? {slow_idx_w, 1'b1} : {slow_idx_w, 1'b0};
   logic fast_q;
   logic slow_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
         fast_q <= 1'b0;
         slow_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         fast_q <= cnt_d[fast_bit_w];
         slow_q <= cnt_d[slow_bit_w];
      end
   end
   assign fast_divided_output = fast_q;
   assign slow_divided_output = slow_q;

   assign status_w = {8'h00, cnt_q, 1'b0, por_done_q, osc_level_q,
                      cfg_out_q, 1'b0, slow_q, fast_q, 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   property p_osc_spacing;
      @(posedge pclk) disable iff (!presetn)
      half_tick_w |=> !half_tick_w ##[1:2] half_tick_w;
   endproperty
   a_osc_spacing: assert property (p_osc_spacing) else $error("osc ticks too close");

   property p_por_waits;
      @(posedge pclk) disable iff (!presetn)
      $rose(por_done_q) |-> $past(osc_rise_w) && $past(por_cnt_q) == POR_LAST - 8'h01;
   endproperty
   a_por_waits: assert property (p_por_waits) else $error("power-on done early");

   property p_cfg_12mhz;
      @(posedge pclk) disable iff (!presetn)
      (rate_w == osc_div_pkg::RATE_12MHZ && half_tick_w) |=> $changed(config_clock_out);
   endproperty
   a_cfg_12mhz: assert property (p_cfg_12mhz) else $error("12 MHz cfg flip missed");

   property p_cfg_only_on_tick;
      @(posedge pclk) disable iff (!presetn)
      $changed(config_clock_out) |-> $past(half_tick_w);
   endproperty
   a_cfg_only_on_tick: assert property (p_cfg_only_on_tick) else $error("cfg clock off tick");

   property p_src_user;
      @(posedge pclk) disable iff (!presetn)
      (src_w == osc_div_pkg::SRC_USER && !user_rise_w) |=> $stable(cnt_q);
   endproperty
   a_src_user: assert property (p_src_user) else $error("counter moved without user edge");

   property p_cnt_step;
      @(posedge pclk) disable iff (!presetn)
      src_edge_w |=> cnt_q == $past(cnt_q) + 16'h0001;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter missed source edge");

   property p_fast_bit;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> fast_divided_output == cnt_q[$past(fast_bit_w)];
   endproperty
   a_fast_bit: assert property (p_fast_bit) else $error("fast output wrong tap");

   property p_slow_bit;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> slow_divided_output == cnt_q[$past(slow_bit_w)];
   endproperty
   a_slow_bit: assert property (p_slow_bit) else $error("slow output wrong tap");

   property p_ctrl_write;
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl_w |=> ctrl_q == ($past(pwdata) & 32'h0000_0737);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_one_wait;
      @(posedge pclk) disable iff (!presetn)
      (access_w && !pready_q) |=> pready_q;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("apb answer late");

   property p_one_pulse;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("apb answer held too long");

   property p_read_ctrl;
      @(posedge pclk) disable iff (!presetn)
      (access_w && !pready_q && !pwrite && sel_ctrl_w) |=> prdata == $past(ctrl_q);
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      (access_w && !pready_q && !mapped_w) |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

   property p_ctrl_kept;
      @(posedge pclk) disable iff (!presetn)
      !wr_ctrl_w |=> $stable(ctrl_q);
   endproperty
   a_ctrl_kept: assert property (p_ctrl_kept) else $error("control changed unasked");

   property p_por_sticky;
      @(posedge pclk) disable iff (!presetn)
      por_done_q |=> por_done_q;
   endproperty
   a_por_sticky: assert property (p_por_sticky) else $error("power-on done fell");

   property p_src_osc;
      @(posedge pclk) disable iff (!presetn)
      (src_w == osc_div_pkg::SRC_OSC && !osc_rise_w) |=> $stable(cnt_q);
   endproperty
   a_src_osc: assert property (p_src_osc) else $error("counter moved off osc edge");

   // the spare rate code must behave as the default
   property p_cfg_default;
      @(posedge pclk) disable iff (!presetn)
      (rate_w != osc_div_pkg::RATE_6MHZ && rate_w != osc_div_pkg::RATE_12MHZ) |->
         cfg_half_w == 4'(`CFG_HALF_1MHZ);
   endproperty
   a_cfg_default: assert property (p_cfg_default) else $error("1 MHz default lost");

   c_user_src: cover property (@(posedge pclk) disable iff (!presetn)
      src_w == osc_div_pkg::SRC_USER && user_rise_w);
   c_cfg_6mhz: cover property (@(posedge pclk) disable iff (!presetn)
      rate_w == osc_div_pkg::RATE_6MHZ && cfg_flip_w);
   c_slow_65536: cover property (@(posedge pclk) disable iff (!presetn)
      slow_idx_w == 3'h7 && $rose(slow_divided_output));
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr_q);
   c_cfg_default: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[`CTRL_RATE_MSB:`CTRL_RATE_LSB] == 2'h3 && cfg_flip_w);

endmodule : oscillator_clock_divider
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the oscillator, config clock and divider
`timescale 1ns/100ps
`default_nettype none
`include "osc_div_defs.svh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic user_clock = 1'b0;
   logic uclk_on = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, config_clock_out, fast_divided_output, slow_divided_output, por_done;
   int ucnt = 0;
   int cycles = 0;
   int miscompares = 0;
   int cmp_count = 0;
   always #10 pclk = ~pclk;
   oscillator_clock_divider uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .user_clock(user_clock),
      .config_clock_out(config_clock_out), .fast_divided_output(fast_divided_output),
      .slow_divided_output(slow_divided_output), .por_done(por_done));
   ////////////////////////////////////////////////////////////////////////////////
   // user clock: 24 pclk period, phase unrelated to the oscillator model
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (uclk_on) begin
         ucnt <= (ucnt == 11) ? 0 : ucnt + 1;
         if (ucnt == 11) user_clock <= ~user_clock;
      end
      if (cycles == 60000) begin
         miscompares++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // edge counts jitter by one with the oscillator phase
   task near(input int got, input int exp);
      check(32'((got >= exp - 1 && got <= exp + 1) ? exp : got), 32'(exp));
   endtask : near
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      if (n == 50) check(32'(pready), 32'h0000_0001);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task count(input int len, output int n[3]);
      logic [2:0] prev, cur;
      n = '{0, 0, 0};
      prev = {slow_divided_output, fast_divided_output, config_clock_out};
      repeat (len) begin
         @(negedge pclk);
         cur = {slow_divided_output, fast_divided_output, config_clock_out};
         for (int i = 0; i < 3; i++) if (cur[i] && !prev[i]) n[i]++;
         prev = cur;
      end
   endtask : count
   ////////////////////////////////////////////////////////////////////////////////
   task t_por;
      int n;
      n = 0;
      while (por_done !== 1'b1 && n < 2000) begin
         @(negedge pclk);
         n++;
      end
      near(n / 10, 106);
      $display("test por done");
   endtask : t_por
   task t_regs;
      logic [31:0] r;
      logic e;
      apb(1'b0, `CTRL_OFFSET, 32'h0000_0000, r, e);
      check(r, `CTRL_RESET);
      apb(1'b1, `CTRL_OFFSET, 32'hFFFF_FFFF, r, e);
      apb(1'b1, `STATUS_OFFSET, 32'h0000_0000, r, e);
      check(32'(e), 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0000, r, e);
      check(32'(e), 32'h0000_0001);
      apb(1'b0, 12'h008, 32'h0000_0000, r, e);
      check({r[30:0], e}, 32'h0000_0001);
      apb(1'b0, `CTRL_OFFSET, 32'h0000_0000, r, e);
      check(r, 32'h0000_0737);
      apb(1'b1, `CTRL_OFFSET, 32'h0000_0000, r, e);
      $display("test regs done");
   endtask : t_regs
   // 1000 pclk is 20 us: 20, 120 and 240 periods; code 3 falls back to 1 MHz
   task t_cfg_clock;
      int n[3];
      int exp_e[4] = '{20, 120, 240, 20};
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `CTRL_OFFSET, 32'(i), r, e);
         count(1000, n);
         near(n[0], exp_e[i]);
      end
      $display("test cfg clock done");
   endtask : t_cfg_clock
   task t_freq;
      int n[3];
      logic [31:0] r;
      logic e;
      apb(1'b1, `CTRL_OFFSET, 32'h0000_0000, r, e);
      count(1000, n);
      near(n[1], 60);
      near(n[2], 120);
      apb(1'b1, `CTRL_OFFSET, 32'h0000_0110, r, e);
      count(1000, n);
      near(n[1], 15);
      near(n[2], 30);
      $display("test freq done");
   endtask : t_freq
   // long ratios: output must follow its counter tap
   task t_taps;
      int sb[8] = '{0, 2, 4, 6, 9, 11, 13, 15};
      logic [31:0] r;
      logic e;
      for (int j = 0; j < 8; j++) begin
         apb(1'b1, `CTRL_OFFSET, 32'((j << 8) | ((j % 4) << 4)), r, e);
         repeat (4) begin
            apb(1'b0, `STATUS_OFFSET, 32'h0000_0000, r, e);
            check(32'(r[1]), 32'(r[9 + 2 * (j % 4)]));
            check(32'(r[2]), 32'(r[8 + sb[j]]));
         end
      end
      $display("test taps done");
   endtask : t_taps
   // 1152 pclk hold 48 user periods; stopped source must freeze outputs
   task t_user;
      int n[3];
      logic [31:0] r;
      logic e;
      apb(1'b1, `CTRL_OFFSET, 32'h0000_0004, r, e);
      uclk_on <= 1'b1;
      count(1152, n);
      near(n[1], 12);
      near(n[2], 24);
      uclk_on <= 1'b0;
      count(200, n);
      check(32'(n[1] + n[2]), 32'h0000_0000);
      $display("test user done");
   endtask : t_user
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_por();
      t_regs();
      t_cfg_clock();
      t_freq();
      t_taps();
      t_user();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
